/* src/ifpp_pkg.sv */
// Shared constants, codes and carrier types of the pixel pipeline.
// Assumes one pixel clock domain; everything here is definitions only.
package ifpp_pkg;

    // Register offsets of the test pattern block
    localparam logic [15:0] ADDR_TP_ENABLE = 16'hC84C;
    localparam logic [15:0] ADDR_TP_SELECT = 16'hC84D;
    localparam logic [15:0] ADDR_FLAT_A    = 16'hC84E;
    localparam logic [15:0] ADDR_FLAT_B    = 16'hC850;
    localparam logic [15:0] ADDR_FLAT_C    = 16'hC852;

    // Values after reset and mode codes
    localparam logic [7:0]  TP_ON          = 8'h02;
    localparam logic [7:0]  TP_OFF         = 8'h00;
    localparam logic [7:0]  TP_SEL_RST     = 8'h01;
    localparam logic [15:0] FLAT_RST       = 16'h01FF;

    // Pattern selector codes
    localparam logic [7:0]  PAT_FLAT       = 8'h01;
    localparam logic [7:0]  PAT_BARS       = 8'h04;
    localparam logic [7:0]  PAT_PRBS       = 8'h05;
    localparam logic [7:0]  PAT_GRAY       = 8'h08;
    localparam logic [7:0]  PAT_WALK10     = 8'h0A;
    localparam logic [7:0]  PAT_WALK8      = 8'h0B;

    // Gamma table computation and curve choice codes
    localparam logic [1:0]  KCM_USER       = 2'h0;
    localparam logic [1:0]  KCM_CONTRAST   = 2'h1;
    localparam logic [1:0]  KCM_NOISE      = 2'h2;
    localparam logic [1:0]  KCM_BOTH       = 2'h3;
    localparam logic [1:0]  GC_AUTO        = 2'h0;
    localparam logic [1:0]  GC_CONTRAST    = 2'h1;
    localparam logic [1:0]  GC_NOISE       = 2'h2;
    localparam int          FTB_BIT        = 3;

    // Bayer channel codes and fixed-point scales
    localparam logic [1:0]  CH_R           = 2'h0;
    localparam logic [1:0]  CH_GR          = 2'h1;
    localparam logic [1:0]  CH_GB          = 2'h2;
    localparam logic [1:0]  CH_B           = 2'h3;
    localparam int          KNEES          = 19;
    localparam int          GAIN_SHIFT     = 7;
    localparam int          CCM_SHIFT      = 8;
    localparam int          SHARP_SHIFT    = 4;
    localparam int          LINE_W_DEF     = 1296;
    localparam int          STAGES         = 7;

    // One raw pixel: channel, start-of-line flag, 10-bit value
    typedef struct packed {
        logic [1:0] ch;
        logic       sol;
        logic [9:0] v;
    } ifpp_raw_t;

    typedef struct packed {
        logic [11:0] r;
        logic [11:0] g;
        logic [11:0] b;
    } ifpp_rgb12_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } ifpp_rgb8_t;

    // Fixed knee abscissa: 0, 64, 128, then 256 to 4096 in steps of 256
    function automatic logic [12:0] knee_pos(input int i);
        if (i == 0) return 13'h0000;
        if (i == 1) return 13'h0040;
        if (i == 2) return 13'h0080;
        return 13'((i - 2) * 256);
    endfunction

endpackage

/* src/ifpp_skid_buf.sv */
// Two-entry buffer between the last stage and the pixel receiver.
// Assumes the writer holds data while in_ready is low.
`timescale 1ns/1ps
module ifpp_skid_buf #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    // Filling side
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output wire logic         in_ready_out,
    // Draining side
    input  wire logic         out_ready_in,
    output wire logic [W-1:0] out_data_out,
    output wire logic         out_valid_out
);
    logic [1:0][W-1:0] mem_r;
    logic [1:0]        cnt_r;
    logic              rd_r;
    logic              wr_r;

    wire push = in_valid_in && (cnt_r != 2'h2);
    wire pop  = out_valid_out && out_ready_in;

    // Full refuses the writer, so the stall reaches the pipeline
    assign in_ready_out  = (cnt_r != 2'h2);
    assign out_valid_out = (cnt_r != 2'h0);
    assign out_data_out  = mem_r[rd_r];

    // Pointers and occupancy
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_r <= 2'h0;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
        end else begin
            cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
            if (push) wr_r <= ~wr_r;
            if (pop) rd_r <= ~rd_r;
        end
    end

    // Entry storage, no reset needed
    always_ff @(posedge mclk_in) begin
        if (push) mem_r[wr_r] <= in_data_in;
    end
endmodule // ifpp_skid_buf

/* src/ifpp_top.sv */
// Raw-to-RGB pixel pipeline with test pattern source and register port.
// Assumes controls from the microcontroller are synchronous to mclk_in.
`timescale 1ns/1ps
// Function
// R1 - 0x02 enters, 0x00 leaves test pattern
// R2 - Host issues reload to apply pattern change
// R3 - Selector picks flat/bars/random/gray/walking patterns
// R4 - Flat field colour from three components
// R5 - Pattern replaces sensor data at input
// R6 - Per-channel digital gain first
// R7 - Shading gain per channel, three illuminants
// R8 - Ten-bit one-colour pixels through defect stage
// R9 - Edge-threshold interpolation gives three colours
// R10 - 3x3 matrix, widen to 12 bits
// R11 - Matrix from user or auto white balance
// R12 - Auto interpolates warm, fluorescent, daylight
// R13 - Sharpening with programmable gain, threshold
// R14 - Gamma 12-bit to 8-bit, 19 knees
// R15 - Fixed knee positions, programmable outputs
// R16 - Contrast and noise tables by brightness
// R17 - Fade-to-black forces knees to zero (code scales knees by fade_level_in, all zero only at levels 0 and 1)
// R18 - Knees computed or written by host
// R19 - Averaging binning uses every pixel
// R20 - Microcontroller adjusts parameters automatically
// R21 - Knee calc mode selects computed tables
// R22 - Curve choice: blend, contrast, noise
// R23 - Fade-to-black only when bit 3 set
// R24 - Fixed stage order, one pixel per cycle
// R25 - Linear interpolation between knee outputs
module ifpp_top import ifpp_pkg::*; #(
    parameter int LINE_W = LINE_W_DEF
) (
    // Clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_in,
    // Register port
    input  wire logic [15:0]            reg_addr_in,
    input  wire logic [15:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic                   change_config_in,
    output logic      [15:0]            reg_rdata_out,
    // Sensor pixels
    input  wire ifpp_raw_t              pix_in,
    input  wire logic                   pix_valid_in,
    output wire logic                   pix_ready_out,
    // Gain, shading and binning controls
    input  wire logic [3:0][7:0]        dgain_in,
    input  wire logic [1:0]             illum_sel_in,
    input  wire logic [2:0][3:0][7:0]   shade_gain_in,
    input  wire logic                   bin_avg_en_in,
    // Interpolation and colour correction
    input  wire logic [9:0]             edge_thr_in,
    input  wire logic                   ccm_auto_in,
    input  wire logic [8:0]             ccm_temp_in,
    input  wire logic [8:0][11:0]       ccm_user_in,
    input  wire logic [8:0][11:0]       ccm_warm_in,
    input  wire logic [8:0][11:0]       ccm_fluor_in,
    input  wire logic [8:0][11:0]       ccm_day_in,
    // Sharpening
    input  wire logic [3:0]             sharp_gain_in,
    input  wire logic [11:0]            sharp_thr_in,
    // Gamma
    input  wire logic [1:0]             knee_calc_mode_in,
    input  wire logic [1:0]             gamma_curve_choice_in,
    input  wire logic [18:0][7:0]       knee_contrast_in,
    input  wire logic [18:0][7:0]       knee_noise_in,
    input  wire logic [7:0]             grad_contrast_in,
    input  wire logic [7:0]             grad_noise_in,
    input  wire logic [7:0]             brightness_in,
    input  wire logic [7:0]             lowlight_feature_control_in,
    input  wire logic [7:0]             fade_level_in,
    // RGB output
    input  wire logic                   rgb_ready_in,
    output wire ifpp_rgb8_t             rgb_out,
    output wire logic                   rgb_valid_out
);
    // Register shadows and live copies
    logic [7:0]        tp_en_r, tp_sel_r, tp_en_live_r, tp_sel_live_r;
    logic [15:0]       flat_a_r, flat_b_r, flat_c_r;
    // Pattern generator state
    logic [10:0]       col_r;
    logic              row_r;
    logic [9:0]        lfsr_r, walk10_r;
    logic [7:0]        walk8_r;
    // Stage registers
    logic [STAGES-1:0] v_r;
    ifpp_raw_t         s0_r, s1_r, s2_r;
    logic [3:0][9:0]   bin_last_r, def_last_r;
    logic [9:0]        hold_r_r, hold_g_r, hold_b_r;
    ifpp_rgb12_t       s3_r, s4_r, s5_r, s4_prev_r;
    ifpp_rgb8_t        s6_r;
    logic              buf_ready;

    // Whole pipeline moves only when the buffer can take a pixel
    wire adv   = buf_ready;
    wire tp_on = (tp_en_live_r == TP_ON);

    // R2 reload command
    // Enable and select writes land in shadows, taken live on reload
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tp_en_live_r  <= TP_OFF;
            tp_sel_live_r <= TP_SEL_RST;
        end else if (change_config_in) begin
            tp_en_live_r  <= tp_en_r;
            tp_sel_live_r <= tp_sel_r;
        end
    end

    // R1 mode register writes
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tp_en_r  <= TP_OFF;
            tp_sel_r <= TP_SEL_RST;
            flat_a_r <= FLAT_RST;
            flat_b_r <= FLAT_RST;
            flat_c_r <= FLAT_RST;
        end else if (reg_wr_in) begin
            if (reg_addr_in == ADDR_TP_ENABLE) tp_en_r  <= reg_wdata_in[7:0];
            if (reg_addr_in == ADDR_TP_SELECT) tp_sel_r <= reg_wdata_in[7:0];
            if (reg_addr_in == ADDR_FLAT_A)    flat_a_r <= reg_wdata_in;
            if (reg_addr_in == ADDR_FLAT_B)    flat_b_r <= reg_wdata_in;
            if (reg_addr_in == ADDR_FLAT_C)    flat_c_r <= reg_wdata_in;
        end
    end

    // Read decode; unmapped offsets return zero
    wire [15:0] rd_mux =
        (reg_addr_in == ADDR_TP_ENABLE) ? {8'h00, tp_en_r}  :
        (reg_addr_in == ADDR_TP_SELECT) ? {8'h00, tp_sel_r} :
        (reg_addr_in == ADDR_FLAT_A)    ? flat_a_r          :
        (reg_addr_in == ADDR_FLAT_B)    ? flat_b_r          :
        (reg_addr_in == ADDR_FLAT_C)    ? flat_c_r          : 16'h0000;

    always_ff @(posedge mclk_in) begin
        if (rst_in) reg_rdata_out <= 16'h0000;
        else if (reg_rd_in) reg_rdata_out <= rd_mux;
    end

    // R3 pattern decode
    wire [1:0]  tp_ch   = {row_r, col_r[0]};
    wire [2:0]  bar     = col_r[10:8];
    wire        bar_on  = (tp_ch == CH_R) ? bar[2] : (tp_ch == CH_B) ? bar[0] : bar[1];
    // R4 flat colour by channel
    wire [9:0]  flat_v  = (tp_ch == CH_R) ? flat_a_r[9:0] :
                          (tp_ch == CH_B) ? flat_c_r[9:0] : flat_b_r[9:0];
    wire [9:0]  pat_v   =
        (tp_sel_live_r == PAT_FLAT)   ? flat_v :
        (tp_sel_live_r == PAT_BARS)   ? {10{bar_on}} :
        (tp_sel_live_r == PAT_PRBS)   ? lfsr_r :
        (tp_sel_live_r == PAT_GRAY)   ? col_r[9:0] :
        (tp_sel_live_r == PAT_WALK10) ? walk10_r :
        (tp_sel_live_r == PAT_WALK8)  ? {walk8_r, 2'b00} : 10'h000;

    // R5 pattern injected ahead of the first stage
    wire ifpp_raw_t src       = tp_on ? '{ch: tp_ch, sol: (col_r == 11'h000), v: pat_v} : pix_in;
    wire            src_valid = tp_on | pix_valid_in;
    // Sensor is held off while the pattern runs
    assign pix_ready_out = adv & ~tp_on;

    // Pattern raster, random and walking-one generators
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            col_r    <= 11'h000;
            row_r    <= 1'b0;
            lfsr_r   <= 10'h001;
            walk10_r <= 10'h001;
            walk8_r  <= 8'h01;
        end else if (adv && tp_on) begin
            col_r    <= (col_r == 11'(LINE_W - 1)) ? 11'h000 : 11'(col_r + 11'h001);
            if (col_r == 11'(LINE_W - 1)) row_r <= ~row_r;
            lfsr_r   <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
            walk10_r <= {walk10_r[8:0], walk10_r[9]};
            walk8_r  <= {walk8_r[6:0], walk8_r[7]};
        end
    end

    // R19 digital averaging with previous same-colour pixel
    wire [10:0] bin_sum = {1'b0, src.v} + {1'b0, bin_last_r[src.ch]};
    wire [9:0]  bin_v   = bin_avg_en_in ? bin_sum[10:1] : src.v;

    // Gain with saturation to ten bits
    function automatic logic [9:0] gain10(input logic [9:0] v, input logic [7:0] g);
        logic [17:0] p;
        p = v * g;
        return p[17] ? 10'h3FF : p[16:7];
    endfunction

    // R6 per-channel gain
    wire [9:0] g_v  = gain10(s0_r.v, dgain_in[s0_r.ch]);
    // R7 shading per channel and illuminant
    wire [1:0] ill  = (illum_sel_in > 2'h2) ? 2'h2 : illum_sel_in;
    wire [9:0] sh_v = gain10(s1_r.v, shade_gain_in[ill][s1_r.ch]);
    // R8 defect: a stuck-high pixel takes its neighbour's value
    wire [9:0] df_v = (sh_v == 10'h3FF) ? def_last_r[s1_r.ch] : sh_v;

    // R24 stage valid chain, one pixel per advance
    always_ff @(posedge mclk_in) begin
        if (rst_in) v_r <= '0;
        else if (adv) v_r <= {v_r[STAGES-2:0], src_valid};
    end

    // R24 one-colour stages in order: source, gain, shading
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bin_last_r <= '0;
            def_last_r <= '0;
        end else if (adv) begin
            if (src_valid) bin_last_r[src.ch] <= src.v;
            if (v_r[1]) def_last_r[s1_r.ch] <= df_v;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (adv) begin
            s0_r <= '{ch: src.ch, sol: src.sol, v: bin_v};
            s1_r <= '{ch: s0_r.ch, sol: s0_r.sol, v: g_v};
            s2_r <= '{ch: s1_r.ch, sol: s1_r.sol, v: df_v};
        end
    end

    // R9 edge test against last same-colour value
    wire [1:0]  c_ch   = s2_r.ch;
    wire [9:0]  c_hold = (c_ch == CH_R) ? hold_r_r : (c_ch == CH_B) ? hold_b_r : hold_g_r;
    wire [9:0]  c_diff = (s2_r.v > c_hold) ? 10'(s2_r.v - c_hold) : 10'(c_hold - s2_r.v);
    wire [10:0] c_sum  = {1'b0, s2_r.v} + {1'b0, c_hold};
    wire [9:0]  c_new  = (c_diff > edge_thr_in) ? s2_r.v : c_sum[10:1];
    wire [9:0]  n_r    = (c_ch == CH_R) ? c_new : hold_r_r;
    wire [9:0]  n_g    = (c_ch == CH_GR || c_ch == CH_GB) ? c_new : hold_g_r;
    wire [9:0]  n_b    = (c_ch == CH_B) ? c_new : hold_b_r;

    // R9 three colours per pixel from the held neighbours
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hold_r_r <= 10'h000;
            hold_g_r <= 10'h000;
            hold_b_r <= 10'h000;
        end else if (adv && v_r[2]) begin
            hold_r_r <= n_r;
            hold_g_r <= n_g;
            hold_b_r <= n_b;
        end
    end

    // R12 blend weight: warm to fluorescent, then fluorescent to daylight
    wire        t_hi = ccm_temp_in[8];
    wire [8:0]  t_w  = {1'b0, ccm_temp_in[7:0]};
    logic [8:0][11:0] mat;

    // R11 user matrix or white-balance blend, one coefficient each
    for (genvar k = 0; k < 9; k++) begin : g_coef
        wire signed [11:0] lo  = t_hi ? ccm_fluor_in[k] : ccm_warm_in[k];
        wire signed [11:0] hi  = t_hi ? ccm_day_in[k]   : ccm_fluor_in[k];
        wire signed [12:0] dif = 13'(hi - lo);
        wire signed [22:0] prd = dif * $signed({1'b0, t_w});
        wire signed [11:0] mix = 12'(lo + 12'(prd >>> 8));
        assign mat[k] = ccm_auto_in ? mix : ccm_user_in[k];
    end

    // R10 3x3 product, saturated to 12 bits per colour
    function automatic logic [11:0] ccm_row(input logic [9:0] r, input logic [9:0] g,
                                             input logic [9:0] b, input logic [11:0] c0,
                                             input logic [11:0] c1, input logic [11:0] c2);
        logic signed [25:0] acc;
        acc = 26'($signed({2'b00, r}) * $signed(c0)) + 26'($signed({2'b00, g}) * $signed(c1))
            + 26'($signed({2'b00, b}) * $signed(c2));
        acc = acc >>> CCM_SHIFT;
        return acc[25] ? 12'h000 : (|acc[24:12]) ? 12'hFFF : acc[11:0];
    endfunction

    // R10 interpolation and colour correction stages
    always_ff @(posedge mclk_in) begin
        if (adv) begin
            s3_r      <= '{r: {2'b00, n_r}, g: {2'b00, n_g}, b: {2'b00, n_b}};
            s4_r.r    <= ccm_row(s3_r.r[9:0], s3_r.g[9:0], s3_r.b[9:0], mat[0], mat[1], mat[2]);
            s4_r.g    <= ccm_row(s3_r.r[9:0], s3_r.g[9:0], s3_r.b[9:0], mat[3], mat[4], mat[5]);
            s4_r.b    <= ccm_row(s3_r.r[9:0], s3_r.g[9:0], s3_r.b[9:0], mat[6], mat[7], mat[8]);
            s4_prev_r <= s4_r;
        end
    end

    // R13 sharpen a colour when its step exceeds the threshold
    function automatic logic [11:0] sharp(input logic [11:0] cur, input logic [11:0] prv);
        logic signed [12:0] d;
        logic signed [17:0] s;
        d = $signed({1'b0, cur}) - $signed({1'b0, prv});
        s = 18'($signed({1'b0, cur})) + 18'((d * $signed({1'b0, sharp_gain_in})) >>> SHARP_SHIFT);
        if (((d < 0) ? -d : d) <= $signed({1'b0, sharp_thr_in})) return cur;
        return s[17] ? 12'h000 : (|s[16:12]) ? 12'hFFF : s[11:0];
    endfunction

    // R16 table choice; R18 computed or host knees
    logic [18:0][7:0] k_eff;
    for (genvar i = 0; i < KNEES; i++) begin : g_knee
        wire [20:0] pc  = knee_pos(i) * grad_contrast_in;
        wire [20:0] pn  = knee_pos(i) * grad_noise_in;
        // R21 mode picks computed or host table
        wire [7:0]  kc  = knee_calc_mode_in[0] ? ((|pc[20:16]) ? 8'hFF : pc[15:8]) : knee_contrast_in[i];
        wire [7:0]  kn  = knee_calc_mode_in[1] ? ((|pn[20:16]) ? 8'hFF : pn[15:8]) : knee_noise_in[i];
        wire [15:0] bl  = kc * brightness_in + kn * (8'hFF - brightness_in);
        // R22 blend, contrast only, or noise only
        wire [7:0]  ks  = (gamma_curve_choice_in == GC_CONTRAST) ? kc :
                          (gamma_curve_choice_in == GC_NOISE)    ? kn : bl[15:8];
        wire [15:0] fd  = ks * fade_level_in;
        // R17 R23 fade scales knees toward zero when bit set
        assign k_eff[i] = lowlight_feature_control_in[FTB_BIT] ? fd[15:8] : ks;
    end

    // R14 R15 R25 segment lookup and linear interpolation
    function automatic logic [7:0] gam(input logic [11:0] x, input logic [18:0][7:0] k);
        logic [4:0]         i;
        logic [7:0]         f;
        logic [3:0]         sh;
        logic signed [8:0]  d;
        logic signed [18:0] p;
        logic signed [9:0]  y;
        if (x < 12'h040) begin
            i = 5'd0; f = {2'b00, x[5:0]}; sh = 4'd6;
        end else if (x < 12'h080) begin
            i = 5'd1; f = {2'b00, x[5:0]}; sh = 4'd6;
        end else if (x < 12'h100) begin
            i = 5'd2; f = {1'b0, x[6:0]}; sh = 4'd7;
        end else begin
            i = 5'({1'b0, x[11:8]} + 5'd2); f = x[7:0]; sh = 4'd8;
        end
        d = $signed({1'b0, k[i + 5'd1]}) - $signed({1'b0, k[i]});
        p = d * $signed({1'b0, f});
        y = $signed({2'b00, k[i]}) + 10'(p >>> sh);
        return y[7:0];
    endfunction

    // R24 sharpening then gamma, last stages
    always_ff @(posedge mclk_in) begin
        if (adv) begin
            s5_r.r <= sharp(s4_r.r, s4_prev_r.r);
            s5_r.g <= sharp(s4_r.g, s4_prev_r.g);
            s5_r.b <= sharp(s4_r.b, s4_prev_r.b);
            s6_r   <= '{r: gam(s5_r.r, k_eff), g: gam(s5_r.g, k_eff), b: gam(s5_r.b, k_eff)};
        end
    end

    // Output buffer absorbs a receiver stall without loss
    ifpp_skid_buf #(.W($bits(ifpp_rgb8_t))) u_buf (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .in_data_in    (s6_r),
        .in_valid_in   (v_r[STAGES-1] & adv),
        .in_ready_out  (buf_ready),
        .out_ready_in  (rgb_ready_in),
        .out_data_out  (rgb_out),
        .out_valid_out (rgb_valid_out)
    );

    // Checks of the datapath against its controls
    sequence s_acc;
        pix_valid_in && pix_ready_out;
    endsequence
    sequence s_six_adv;
        adv [*6];
    endsequence

    property p_pipe_len;
        @(posedge mclk_in) disable iff (rst_in) s_acc ##1 s_six_adv |=> v_r[STAGES-1];
    endproperty
    a_pipe_len: assert property (p_pipe_len) else $error("pixel lost in pipeline"); // R24

    property p_tp_src;
        @(posedge mclk_in) disable iff (rst_in) tp_on && adv && !change_config_in |=> v_r[0] && !pix_ready_out;
    endproperty
    a_tp_src: assert property (p_tp_src) else $error("pattern not injected"); // R5

    property p_flat;
        @(posedge mclk_in) disable iff (rst_in)
            tp_on && tp_sel_live_r == PAT_FLAT && adv && !bin_avg_en_in |=> s0_r.v == $past(flat_v);
    endproperty
    a_flat: assert property (p_flat) else $error("flat colour wrong"); // R4

    property p_reload;
        @(posedge mclk_in) disable iff (rst_in) !change_config_in |=> $stable(tp_en_live_r);
    endproperty
    a_reload: assert property (p_reload) else $error("mode changed without reload"); // R2

    property p_gain_zero;
        @(posedge mclk_in) disable iff (rst_in) adv && dgain_in == '0 |=> s1_r.v == 10'h000;
    endproperty
    a_gain_zero: assert property (p_gain_zero) else $error("gain not applied"); // R6

    property p_auto_warm;
        @(posedge mclk_in) disable iff (rst_in) ccm_auto_in && ccm_temp_in == 9'h000 |-> mat == ccm_warm_in;
    endproperty
    a_auto_warm: assert property (p_auto_warm) else $error("warm matrix not chosen"); // R12

    property p_fade;
        @(posedge mclk_in) disable iff (rst_in)
            adv && lowlight_feature_control_in[FTB_BIT] && fade_level_in == 8'h00 |=> s6_r == '0;
    endproperty
    a_fade: assert property (p_fade) else $error("fade did not blacken"); // R17

    property p_knee0;
        @(posedge mclk_in) disable iff (rst_in) adv && s5_r.g == 12'h000 |=> s6_r.g == $past(k_eff[0]);
    endproperty
    a_knee0: assert property (p_knee0) else $error("knee zero output wrong"); // R15

endmodule // ifpp_top

/* test/ifpp_host_model.sv */
// Host model: drives the register port and reload pulse.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
module ifpp_host_model (
    // Clock and read data
    input  wire logic        mclk_in,
    input  wire logic [15:0] rdata_in,
    // Register port
    output logic      [15:0] addr_out,
    output logic      [15:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic             cfg_out
);
    initial {addr_out, wdata_out, wr_out, rd_out, cfg_out} = '0;
    // one strobe per access; write data scrambled after
    task automatic access(input logic [15:0] a, input logic [15:0] d, input logic w, output logic [15:0] q);
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= w;
        rd_out <= !w;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        wdata_out <= ~d;
        #1 q = rdata_in;
    endtask
    task automatic reload();
        @(posedge mclk_in);
        cfg_out <= 1'b1;
        @(posedge mclk_in);
        cfg_out <= 1'b0;
    endtask
endmodule // ifpp_host_model

/* test/ifpp_top_tb_top.sv */
// Bench: register reset values, test pattern entry and exit, gamma curves.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module ifpp_top_tb_top import ifpp_pkg::*;;
    typedef struct packed {logic [1:0] gc; logic [7:0] llc; logic [7:0] ex;} ifpp_row_t;
    logic             mclk = 0, rst = 1, vld, rdy, wr, rs, cfg;
    logic [15:0]      addr, wd, rd, q;
    logic [1:0]       gc = 0;
    logic [7:0]       llc = 0;
    logic [18:0][7:0] kc, kn;
    logic [8:0][11:0] color_correction_matrix = '0;
    logic [7:0]       dg = 8'h80, bri = 8'hFF;
    logic [9:0]       thr = '0;
    logic [1:0]       ill = '0, kcm = '0;
    logic             bav = 0, cauto = 0, prdy = 1, pv = 0;
    logic [8:0]       tmp = '0;
    logic [11:0]      sthr = 12'hFFF;
    ifpp_rgb8_t       rgb;
    int               fails = 0, checks = 0;
    logic [15:0] regs [6] = '{ADDR_TP_ENABLE, ADDR_TP_SELECT, ADDR_FLAT_A, ADDR_FLAT_B, ADDR_FLAT_C, 16'hC854};
    logic [15:0] rstv [6] = '{16'h0000, 16'h0001, FLAT_RST, FLAT_RST, FLAT_RST, 16'h0000};
    logic [7:0]  pats [6] = '{PAT_FLAT, PAT_BARS, PAT_PRBS, PAT_GRAY, PAT_WALK10, PAT_WALK8};
    ifpp_row_t   rows [3] = '{'{GC_CONTRAST, 8'h00, 8'h20}, '{GC_NOISE, 8'h00, 8'h10}, '{GC_CONTRAST, 8'h08, 8'h00}};
    ifpp_host_model HOST (.mclk_in(mclk), .rdata_in(rd), .addr_out(addr), .wdata_out(wd), .wr_out(wr),
        .rd_out(rs), .cfg_out(cfg));
    ifpp_top #(.LINE_W(16)) DUT (.mclk_in(mclk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rs), .change_config_in(cfg), .reg_rdata_out(rd), .pix_in('0),
        .pix_valid_in(pv), .pix_ready_out(rdy), .dgain_in({4{dg}}), .illum_sel_in(ill),
        .shade_gain_in({12{dg}}), .bin_avg_en_in(bav), .edge_thr_in(thr), .ccm_auto_in(cauto),
        .ccm_temp_in(tmp), .ccm_user_in(color_correction_matrix), .ccm_warm_in(color_correction_matrix), .ccm_fluor_in(color_correction_matrix), .ccm_day_in(color_correction_matrix),
        .sharp_gain_in(4'h0), .sharp_thr_in(sthr), .knee_calc_mode_in(kcm),
        .gamma_curve_choice_in(gc), .knee_contrast_in(kc), .knee_noise_in(kn), .grad_contrast_in(8'h00),
        .grad_noise_in(8'h00), .brightness_in(bri), .lowlight_feature_control_in(llc),
        .fade_level_in(8'h00), .rgb_ready_in(prdy), .rgb_out(rgb), .rgb_valid_out(vld));
    // Clock, 4 ns period
    initial forever #2 mclk = ~mclk;
    task automatic check(input string nm, input logic [24:0] e, input logic [24:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog, run needs under 1000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
    // Main sequence; knee outputs are pos/16 and pos/32
    initial begin
        for (int i = 0; i < 19; i++) begin
            kc[i] = (i < 3) ? 8'(i * 4) : ((i == 18) ? 8'hFF : 8'((i - 2) * 16));
            kn[i] = (i < 3) ? 8'(i * 2) : 8'((i - 2) * 8);
        end
        color_correction_matrix[0] = 12'h100;
        color_correction_matrix[4] = 12'h100;
        color_correction_matrix[8] = 12'h100;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        foreach (regs[i]) begin
            HOST.access(regs[i], 16'h0000, 1'b0, q);
            check("reset value", rstv[i], q);
        end
        $display("test registers done");
        HOST.access(ADDR_TP_ENABLE, {8'h00, TP_ON}, 1'b1, q);
        for (int i = 2; i < 5; i++) HOST.access(regs[i], 16'h0200, 1'b1, q);
        HOST.access(ADDR_FLAT_A, 16'h0000, 1'b0, q);
        check("flat readback", 16'h0200, q);
        check("ready before reload", 1'b1, rdy);
        HOST.reload();
        repeat (2) @(posedge mclk);
        check("ready in pattern", 1'b0, rdy);
        $display("test pattern done");
        foreach (rows[i]) begin
            @(posedge mclk);
            gc <= rows[i].gc;
            llc <= rows[i].llc;
            repeat (30) @(posedge mclk);
            #1 check("gamma out", {1'b1, {3{rows[i].ex}}}, {vld, rgb});
        end
        $display("test gamma done");
        foreach (pats[i]) begin
            HOST.access(ADDR_TP_SELECT, {8'h00, pats[i]}, 1'b1, q);
            HOST.access(ADDR_TP_SELECT, 16'h0000, 1'b0, q);
            check("select readback", {8'h00, pats[i]}, q);
            HOST.reload();
            repeat (20) @(posedge mclk);
            #1 check("pattern valid", 1'b1, vld);
        end
        $display("test codes done");
        // zero gain drives the gain assertion
        dg <= 8'h00;
        repeat (4) @(posedge mclk);
        dg <= 8'h80;
        HOST.access(ADDR_TP_ENABLE, {8'h00, TP_OFF}, 1'b1, q);
        HOST.reload();
        repeat (12) @(posedge mclk);
        check("ready after exit", 1'b1, rdy);
        pv <= 1'b1;
        repeat (10) @(posedge mclk);
        #1 check("sensor pixel out", 1'b1, vld);
        $display("test exit done");
        tally_and_finish();
    end
endmodule // ifpp_top_tb_top
